// *** hdl/security_options_pkg.sv ***
// Functional notes
// - Admitting a unit as administrator increments last assigned address.
// - Key generation loads own address as last.
// - Last address: four bytes, MSB at lowest.
// - Stored copy governs pairing; working copy governs reception.
// - Bit 0: four presses, 3 s hold restores.
// - Bit 1: administrator shares key when pairing.
// - Bit 2: pairing may change key; serial always.
// - Bit 3: pairing may generate or accept address.
// - Bit 4 set means node, clear administrator.
// - Role one-to-zero needs both key copies cleared.
// - Key generation button function clears role bit.
// - Bit 5: accept plaintext, else silently discard.
// - Bit 7 clear blocks loosening bits 1,5,7.
// - Prohibited option change answered with negative acknowledge.
// - Lock stays until factory restore.
// - Thirty second hold makes administrator, indicator flashes.
// - Slow flash searching, fast flash after success.
// - Accepted plaintext packet sets plaintext flag.
// - Failed write sets flag byte 0 bit 2.
package security_options_pkg;
  localparam logic [7:0]  A_SEC_NV   = 8'h84;
  localparam logic [7:0]  A_LAST_B3  = 8'h8C;
  localparam logic [7:0]  A_LAST_B2  = 8'h8D;
  localparam logic [7:0]  A_LAST_B1  = 8'h8E;
  localparam logic [7:0]  A_LAST_B0  = 8'h8F;
  localparam logic [7:0]  A_FLAGS1   = 8'hCE;
  localparam logic [7:0]  A_FLAGS0   = 8'hCF;
  localparam logic [7:0]  A_SEC_VOL  = 8'hD4;
  localparam logic [7:0]  ESC_OFFSET = 8'h80;
  localparam logic [7:0]  B_HEADER   = 8'hFF;
  localparam logic [7:0]  B_ESCAPE   = 8'hFE;
  localparam logic [7:0]  B_ACK      = 8'h06;
  localparam logic [7:0]  B_NACK     = 8'h15;
  localparam int          BIT_RESTORE = 0;
  localparam int          BIT_SHARE   = 1;
  localparam int          BIT_KEYCHG  = 2;
  localparam int          BIT_ADDRCHG = 3;
  localparam int          BIT_NODE    = 4;
  localparam int          BIT_PLAIN   = 5;
  localparam int          BIT_CHANGE  = 7;
  localparam int          BIT_WFAIL   = 2;
  localparam int          BIT_PLAINRX = 2;
  localparam logic [7:0]  LOOSEN_MASK = 8'hA2;
  localparam logic [7:0]  OPT_DEFAULT = 8'hCF;
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          TICK_US     = 1000;
  localparam int          TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          RESTORE_S   = 3;
  localparam int          ADMIN_S     = 30;
  localparam int          SHORT_MS    = 500;
  localparam int          SLOW_HALF_MS = 500;
  localparam int          FAST_HALF_MS = 100;
  localparam logic [2:0]  PRESS_COUNT = 3'h4;
  typedef enum logic [5:0] {
    P_HDR   = 6'h01,
    P_SIZE  = 6'h02,
    P_OP    = 6'h04,
    P_ESC   = 6'h08,
    P_RADDR = 6'h10,
    P_WVAL  = 6'h20
  } parse_t;
endpackage

// *** hdl/security_options_join_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module security_options_join_config
  import security_options_pkg::*;
#(
  parameter int unsigned TICK_CYC   = TICK_CYCLES,
  parameter int unsigned RESTORE_MS = RESTORE_S * 1000,
  parameter int unsigned ADMIN_MS   = ADMIN_S * 1000,
  parameter int unsigned SHORT_HOLD = SHORT_MS
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  output logic [7:0]       tx_byte_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  input  wire logic        push_button_input_i,
  input  wire logic        join_admit_i,
  input  wire logic        key_generated_i,
  input  wire logic [31:0] own_address_i,
  input  wire logic        keys_cleared_i,
  input  wire logic        plain_rx_i,
  input  wire logic        pair_search_i,
  input  wire logic        pair_done_i,
  output logic             plain_accept_o,
  output logic             key_share_allow_o,
  output logic             key_change_allow_o,
  output logic             address_change_allow_o,
  output logic             node_role_select_o,
  output logic [31:0]      last_join_address_o,
  output logic             factory_restore_o,
  output logic             key_generate_o,
  output logic             status_indicator_led_o
);

  typedef struct packed {
    logic [7:0]  nv_opt;
    logic [7:0]  vol_opt;
    logic [31:0] last_addr;
    logic [7:0]  flags0;
    logic [7:0]  flags1;
    parse_t      pst;
    logic [23:0] tx_buf;
    logic [1:0]  tx_left;
    logic [13:0] tick_cnt;
    logic [15:0] hold_ms;
    logic [15:0] gap_ms;
    logic [2:0]  presses;
    logic        btn_prev;
    logic        restore_done;
    logic        admin_done;
    logic        restore_pls;
    logic        admin_pls;
    logic [9:0]  led_ms;
    logic        led;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic   resp_nack;

  // A write is legal unless it loosens a locked register or drops the
  // node role while a network key is still held.
  function automatic logic opt_ok(input logic [7:0] old_v,
                                  input logic [7:0] new_v,
                                  input logic       keys_clr);
    logic loosen;
    logic role_drop;
    loosen    = |(~old_v & new_v & LOOSEN_MASK);
    role_drop = old_v[BIT_NODE] & ~new_v[BIT_NODE];
    return (old_v[BIT_CHANGE] | ~loosen)
           & ~(role_drop & ~keys_clr);
  endfunction

  always_comb begin
    logic        tick;
    logic [7:0]  addr;
    logic        go_rd;
    logic        go_wr;
    logic        rd_hit;
    logic [7:0]  rd_val;
    logic        wr_bad;
    logic        half_hit;
    logic        fast;
    logic [9:0]  half;
    state_next = state_reg;
    tick       = state_reg.tick_cnt == 14'(TICK_CYC - 1);
    addr       = rx_byte_i + ESC_OFFSET;
    go_rd      = 1'b0;
    go_wr      = 1'b0;
    rd_hit     = 1'b1;
    rd_val     = 8'h00;
    wr_bad     = 1'b0;
    resp_nack  = 1'b0;
    half_hit   = 1'b0;
    fast       = 1'b0;
    half       = 10'(SLOW_HALF_MS - 1);
    state_next.restore_pls = 1'b0;
    state_next.admin_pls   = 1'b0;
    state_next.tick_cnt    = tick ? 14'h0000 : state_reg.tick_cnt + 14'h0001;

    // Transmit shifter: oldest byte sits in the top lane.
    if (state_reg.tx_left != 2'h0 && tx_ready_i) begin
      state_next.tx_buf  = {state_reg.tx_buf[15:0], 8'h00};
      state_next.tx_left = state_reg.tx_left - 2'h1;
    end

    // Command parser; a header byte always restarts a frame.
    if (rx_valid_i && state_reg.tx_left == 2'h0) begin
      if (rx_byte_i == B_HEADER) begin
        state_next.pst = P_SIZE;
      end else begin
        case (state_reg.pst)
          P_HDR:  state_next.pst = P_HDR;
          P_SIZE: state_next.pst = P_OP;
          P_OP: begin
            state_next.pst = (rx_byte_i == B_ESCAPE) ? P_ESC : P_HDR;
            resp_nack      = rx_byte_i != B_ESCAPE;
          end
          P_ESC: begin
            if (rx_byte_i == B_ESCAPE) begin
              state_next.pst = P_RADDR;
            end else begin
              state_next.pst    = P_WVAL;
              state_next.tx_buf = {addr, 16'h0000};
            end
          end
          P_RADDR: begin
            state_next.pst = P_HDR;
            go_rd          = 1'b1;
          end
          P_WVAL: begin
            state_next.pst = P_HDR;
            go_wr          = 1'b1;
          end
          default: state_next.pst = P_HDR;
        endcase
      end
    end

    if (go_rd) begin
      case (addr)
        A_SEC_NV:  rd_val = state_reg.nv_opt;
        A_SEC_VOL: rd_val = state_reg.vol_opt;
        A_LAST_B3: rd_val = state_reg.last_addr[31:24];
        A_LAST_B2: rd_val = state_reg.last_addr[23:16];
        A_LAST_B1: rd_val = state_reg.last_addr[15:8];
        A_LAST_B0: rd_val = state_reg.last_addr[7:0];
        A_FLAGS0:  rd_val = state_reg.flags0;
        A_FLAGS1:  rd_val = state_reg.flags1;
        default:   rd_hit = 1'b0;
      endcase
      if (rd_hit) begin
        state_next.tx_buf  = {B_ACK, addr, rd_val};
        state_next.tx_left = 2'h3;
      end else begin
        resp_nack = 1'b1;
      end
    end

    // Register writes; the target address was parked in the tx lane.
    if (go_wr) begin
      case (state_reg.tx_buf[23:16])
        A_SEC_NV: begin
          wr_bad = ~opt_ok(state_reg.nv_opt, rx_byte_i, keys_cleared_i);
          if (!wr_bad) state_next.nv_opt = rx_byte_i;
        end
        A_SEC_VOL: begin
          wr_bad = ~opt_ok(state_reg.vol_opt, rx_byte_i, keys_cleared_i);
          if (!wr_bad) state_next.vol_opt = rx_byte_i;
        end
        A_LAST_B3: state_next.last_addr[31:24] = rx_byte_i;
        A_LAST_B2: state_next.last_addr[23:16] = rx_byte_i;
        A_LAST_B1: state_next.last_addr[15:8]  = rx_byte_i;
        A_LAST_B0: state_next.last_addr[7:0]   = rx_byte_i;
        A_FLAGS0:  state_next.flags0 = state_reg.flags0 & rx_byte_i;
        A_FLAGS1:  state_next.flags1 = state_reg.flags1 & rx_byte_i;
        default:   wr_bad = 1'b1;
      endcase
      if (wr_bad) begin
        resp_nack = 1'b1;
      end else begin
        state_next.tx_buf  = {B_ACK, 16'h0000};
        state_next.tx_left = 2'h1;
      end
    end
    if (resp_nack) begin
      state_next.tx_buf  = {B_NACK, 16'h0000};
      state_next.tx_left = 2'h1;
    end

    // Sets are applied after the software clear so a coincident event wins.
    if (resp_nack && go_wr) state_next.flags0[BIT_WFAIL] = 1'b1;
    if (plain_rx_i && state_reg.vol_opt[BIT_PLAIN]) begin
      state_next.flags1[BIT_PLAINRX] = 1'b1;
    end

    // Push-button timing in millisecond ticks.
    state_next.btn_prev = push_button_input_i;
    if (push_button_input_i && !state_reg.btn_prev) begin
      state_next.hold_ms = 16'h0000;
    end else if (push_button_input_i) begin
      if (tick && state_reg.hold_ms != 16'hFFFF) begin
        state_next.hold_ms = state_reg.hold_ms + 16'h0001;
      end
      if (state_reg.hold_ms >= 16'(RESTORE_MS) && !state_reg.restore_done &&
          state_reg.presses == PRESS_COUNT &&
          state_reg.nv_opt[BIT_RESTORE]) begin
        state_next.restore_done = 1'b1;
        state_next.restore_pls  = 1'b1;
      end
      if (state_reg.hold_ms >= 16'(ADMIN_MS) && !state_reg.admin_done) begin
        state_next.admin_done = 1'b1;
        state_next.admin_pls  = 1'b1;
      end
    end else if (state_reg.btn_prev) begin
      if (state_reg.hold_ms < 16'(SHORT_HOLD)) begin
        if (state_reg.presses != PRESS_COUNT) begin
          state_next.presses = state_reg.presses + 3'h1;
        end
      end else begin
        state_next.presses = 3'h0;
      end
      state_next.gap_ms       = 16'h0000;
      state_next.restore_done = 1'b0;
      state_next.admin_done   = 1'b0;
    end else if (tick) begin
      // A long pause between presses abandons the sequence.
      if (state_reg.gap_ms >= 16'(SHORT_HOLD)) begin
        state_next.presses = 3'h0;
      end else begin
        state_next.gap_ms = state_reg.gap_ms + 16'h0001;
      end
    end

    // Address bookkeeping; key generation outranks an admission.
    if (join_admit_i && !state_reg.nv_opt[BIT_NODE]) begin
      state_next.last_addr = state_reg.last_addr + 32'h0000_0001;
    end
    if (key_generated_i || state_reg.admin_pls) begin
      state_next.last_addr = own_address_i;
    end
    if (state_reg.admin_pls) begin
      state_next.nv_opt[BIT_NODE]  = 1'b0;
      state_next.vol_opt[BIT_NODE] = 1'b0;
    end
    if (state_reg.restore_pls) begin
      state_next.nv_opt  = OPT_DEFAULT;
      state_next.vol_opt = OPT_DEFAULT;
    end

    // Indicator: fast while admin hold is confirmed or paired, slow while searching, else off.
    fast = (state_reg.admin_done && push_button_input_i) || pair_done_i;
    if (fast) half = 10'(FAST_HALF_MS - 1);
    if (fast || pair_search_i) begin
      if (tick) begin
        half_hit = state_reg.led_ms >= half;
        state_next.led_ms = half_hit ? 10'h000 : state_reg.led_ms + 10'h001;
        if (half_hit) state_next.led = ~state_reg.led;
      end
    end else begin
      state_next.led_ms = 10'h000;
      state_next.led    = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg         <= '0;
      state_reg.nv_opt  <= OPT_DEFAULT;
      state_reg.vol_opt <= OPT_DEFAULT;
      state_reg.pst     <= P_HDR;
    end else begin
      state_reg <= state_next;
    end
  end

  // The volatile copy governs reception; pairing follows the stored copy.
  assign plain_accept_o = plain_rx_i & state_reg.vol_opt[BIT_PLAIN];
  assign key_share_allow_o = state_reg.nv_opt[BIT_SHARE] &
                             ~state_reg.nv_opt[BIT_NODE];
  assign key_change_allow_o     = state_reg.nv_opt[BIT_KEYCHG];
  assign address_change_allow_o = state_reg.nv_opt[BIT_ADDRCHG];
  assign node_role_select_o     = state_reg.nv_opt[BIT_NODE];
  assign last_join_address_o    = state_reg.last_addr;
  assign factory_restore_o      = state_reg.restore_pls;
  assign key_generate_o         = state_reg.admin_pls;
  assign status_indicator_led_o = state_reg.led;
  assign tx_byte_o              = state_reg.tx_buf[23:16];
  assign tx_valid_o             = state_reg.tx_left != 2'h0;
  assign rx_ready_o             = state_reg.tx_left == 2'h0;

  property p_admit_inc;
    @(posedge mclk_i) disable iff (reset_i)
    join_admit_i && !node_role_select_o && !key_generated_i &&
    !key_generate_o && !rx_valid_i
    |=> last_join_address_o == $past(last_join_address_o) + 32'h0000_0001;
  endproperty
  a_admit_inc: assert property (p_admit_inc)
    else $error("last address not incremented on admission");

  property p_keygen_load;
    @(posedge mclk_i) disable iff (reset_i)
    key_generated_i |=> last_join_address_o == $past(own_address_i);
  endproperty
  a_keygen_load: assert property (p_keygen_load)
    else $error("last address not loaded on key generation");

  property p_lock_sticky;
    @(posedge mclk_i) disable iff (reset_i)
    !state_reg.nv_opt[BIT_CHANGE] && !factory_restore_o
    |=> !state_reg.nv_opt[BIT_CHANGE];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock bit reopened without factory restore");

  property p_role_guard;
    @(posedge mclk_i) disable iff (reset_i)
    $fell(node_role_select_o) |-> $past(keys_cleared_i) ||
                                  $past(key_generate_o) ||
                                  $past(factory_restore_o);
  endproperty
  a_role_guard: assert property (p_role_guard)
    else $error("role dropped while key still held");

  property p_share_locked;
    @(posedge mclk_i) disable iff (reset_i)
    !$past(state_reg.nv_opt[BIT_CHANGE]) && !$past(factory_restore_o)
    |-> !$rose(state_reg.nv_opt[BIT_SHARE]);
  endproperty
  a_share_locked: assert property (p_share_locked)
    else $error("key sharing loosened while locked");

  property p_wfail;
    @(posedge mclk_i) disable iff (reset_i)
    resp_nack && state_reg.pst == P_WVAL
    |=> state_reg.flags0[BIT_WFAIL] && tx_byte_o == B_NACK && tx_valid_o;
  endproperty
  a_wfail: assert property (p_wfail)
    else $error("refused write lacks negative answer or flag");

  property p_plain_flag;
    @(posedge mclk_i) disable iff (reset_i)
    plain_rx_i && state_reg.vol_opt[BIT_PLAIN]
    |=> state_reg.flags1[BIT_PLAINRX];
  endproperty
  a_plain_flag: assert property (p_plain_flag)
    else $error("plaintext flag not set on accepted packet");

  property p_plain_drop;
    @(posedge mclk_i) disable iff (reset_i)
    !state_reg.vol_opt[BIT_PLAIN] |-> !plain_accept_o;
  endproperty
  a_plain_drop: assert property (p_plain_drop)
    else $error("plaintext packet accepted while disabled");

  property p_restore;
    @(posedge mclk_i) disable iff (reset_i)
    factory_restore_o |=> state_reg.nv_opt == OPT_DEFAULT &&
                          state_reg.vol_opt == OPT_DEFAULT;
  endproperty
  a_restore: assert property (p_restore)
    else $error("options not restored to defaults");

endmodule
`default_nettype wire

// *** sim/serial_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input  wire logic       mclk_i,
  output logic [7:0]      cmd_byte_o,
  output logic            cmd_valid_o,
  input  wire logic       cmd_ready_i,
  input  wire logic [7:0] ans_byte_i,
  input  wire logic       ans_valid_i,
  output logic            ans_ready_o
);
  // Extra cycles the host lets pass before taking each answer byte.
  int stall = 0;
  initial begin
    cmd_byte_o = 8'h00;
    cmd_valid_o = 1'b0;
    ans_ready_o = 1'b0;
  end
  task automatic put(input logic [7:0] b);
    cmd_byte_o = b;
    cmd_valid_o = 1'b1;
    for (int i = 0; i < 40 && cmd_ready_i !== 1'b1; i++)
      @(posedge mclk_i) #1;
    @(posedge mclk_i) #1;
  endtask
  // Ready always drops for at least one edge, so two takes never collide.
  task automatic take(output logic [7:0] b);
    b = 8'hxx;
    for (int i = 0; i < 40 && ans_valid_i !== 1'b1; i++)
      @(posedge mclk_i) #1;
    repeat (stall + 1) @(posedge mclk_i) #1;
    if (ans_valid_i === 1'b1)
      b = ans_byte_i;
    ans_ready_o = 1'b1;
    @(posedge mclk_i) #1;
    ans_ready_o = 1'b0;
  endtask
  // A released data line carries the inverse of its last byte.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v,
                           output logic [7:0] r);
    logic [7:0] val;
    val = v;
    if (a == 8'h84 || a == 8'hD4)
      val[6] = 1'b1;
    put(8'hFF);
    put(8'h03);
    put(8'hFE);
    put(a - 8'h80);
    put(val);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~val;
    take(r);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] r,
                          output logic [7:0] ra, output logic [7:0] v);
    put(8'hFF);
    put(8'h03);
    put(8'hFE);
    put(8'hFE);
    put(a - 8'h80);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~(a - 8'h80);
    take(r);
    ra = 8'hxx;
    v = 8'hxx;
    if (r === 8'h06) begin
      take(ra);
      take(v);
    end
  endtask
  // A frame whose first escape is missing must be refused outright.
  task automatic bad_op(output logic [7:0] r);
    put(8'hFF);
    put(8'h03);
    put(8'h54);
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'hAB;
    take(r);
  endtask
endmodule
`default_nettype wire

// *** sim/security_options_join_config_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module security_options_join_config_test
  import security_options_pkg::*;
;
  localparam int TICK = 4;
  localparam int ADMIN = 20;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        push = 1'b0;
  logic        admit = 1'b0;
  logic        keygen = 1'b0;
  logic [31:0] own = 32'h0000_0000;
  logic        cleared = 1'b0;
  logic        plain_rx = 1'b0;
  logic        search = 1'b0;
  logic        paired = 1'b0;
  logic [7:0]  rx_byte, tx_byte, r, ra, v;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic        plain_ok, share, keychg, addrchg, node, restore, keyout, led;
  logic [31:0] last;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_restore = 0;
  int          n_keygen = 0;
  always #50 mclk_i = ~mclk_i;
  // Pulses are counted mid-cycle, clear of the edge that launches them.
  always @(negedge mclk_i) begin
    n_restore += int'(restore === 1'b1);
    n_keygen += int'(keyout === 1'b1);
  end
  security_options_join_config #(
    .TICK_CYC   (TICK),
    .RESTORE_MS (6),
    .ADMIN_MS   (ADMIN),
    .SHORT_HOLD (3)
  ) dut (
    .mclk_i                 (mclk_i),
    .reset_i                (reset_i),
    .rx_byte_i              (rx_byte),
    .rx_valid_i             (rx_valid),
    .rx_ready_o             (rx_ready),
    .tx_byte_o              (tx_byte),
    .tx_valid_o             (tx_valid),
    .tx_ready_i             (tx_ready),
    .push_button_input_i    (push),
    .join_admit_i           (admit),
    .key_generated_i        (keygen),
    .own_address_i          (own),
    .keys_cleared_i         (cleared),
    .plain_rx_i             (plain_rx),
    .pair_search_i          (search),
    .pair_done_i            (paired),
    .plain_accept_o         (plain_ok),
    .key_share_allow_o      (share),
    .key_change_allow_o     (keychg),
    .address_change_allow_o (addrchg),
    .node_role_select_o     (node),
    .last_join_address_o    (last),
    .factory_restore_o      (restore),
    .key_generate_o         (keyout),
    .status_indicator_led_o (led)
  );
  serial_host_model host (
    .mclk_i      (mclk_i),
    .cmd_byte_o  (rx_byte),
    .cmd_valid_o (rx_valid),
    .cmd_ready_i (rx_ready),
    .ans_byte_i  (tx_byte),
    .ans_valid_i (tx_valid),
    .ans_ready_o (tx_ready)
  );
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i) #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] resp);
    host.write_reg(a, d, r);
    check("write answer", 32'(r), 32'(resp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, r, ra, v);
    check("read answer", 32'(r), 32'(B_ACK));
    check("read echo", 32'(ra), 32'(a));
    check("read value", 32'(v), 32'(exp));
  endtask
  // The first toggle is skipped, since the mode change lands mid-period.
  task automatic measure(input int half);
    logic was;
    int   n;
    was = led;
    for (int i = 0; i < 2 * half && led === was; i++)
      step(1);
    was = led;
    n = 0;
    while (n < 2 * half && led === was) begin
      step(1);
      n++;
    end
    check("indicator half period", 32'(n), 32'(half));
  endtask
  task automatic t_reset;
    rd(A_SEC_VOL, OPT_DEFAULT);
    rd(A_SEC_NV, OPT_DEFAULT);
    rd(A_LAST_B0, 8'h00);
    host.read_reg(8'h90, r, ra, v);
    check("unmapped read", 32'(r), 32'(B_NACK));
    check("role", 32'(node), 32'h0);
    check("share", 32'(share), 32'h1);
    check("key change", 32'(keychg), 32'h1);
    check("address change", 32'(addrchg), 32'h1);
  endtask
  task automatic t_address;
    own = 32'h1234_5678;
    keygen = 1'b1;
    step(1);
    keygen = 1'b0;
    check("last after key", last, own);
    rd(A_LAST_B3, 8'h12);
    rd(A_LAST_B0, 8'h78);
    repeat (2) begin
      admit = 1'b1;
      step(1);
      admit = 1'b0;
      step(1);
    end
    check("last after joins", last, own + 32'h2);
  endtask
  task automatic t_plain;
    plain_rx = 1'b1;
    #10;
    check("plain drop", 32'(plain_ok), 32'h0);
    step(1);
    plain_rx = 1'b0;
    rd(A_FLAGS1, 8'h00);
    wr(A_SEC_VOL, 8'hEF, B_ACK);
    rd(A_SEC_NV, OPT_DEFAULT);
    plain_rx = 1'b1;
    #10;
    check("plain accept", 32'(plain_ok), 32'h1);
    step(1);
    plain_rx = 1'b0;
    rd(A_FLAGS1, 8'h04);
  endtask
  task automatic t_lock;
    host.stall = 3;
    wr(A_SEC_NV, 8'h4F, B_ACK);
    wr(A_SEC_NV, 8'hCF, B_NACK);
    rd(A_FLAGS0, 8'h04);
    wr(A_SEC_NV, 8'h4D, B_ACK);
    check("share off", 32'(share), 32'h0);
    wr(A_SEC_NV, 8'h4F, B_NACK);
    wr(A_SEC_NV, 8'h6D, B_NACK);
    wr(A_SEC_NV, 8'h41, B_ACK);
    check("key change off", 32'(keychg), 32'h0);
    check("address change off", 32'(addrchg), 32'h0);
    rd(A_SEC_NV, 8'h41);
    host.stall = 0;
  endtask
  task automatic t_bus;
    wr(A_LAST_B3, 8'hC3, B_ACK);
    check("last after bus write", last, 32'hC334_567A);
    wr(A_FLAGS0, 8'h00, B_ACK);
    rd(A_FLAGS0, 8'h00);
    wr(8'h90, 8'h00, B_NACK);
    rd(A_FLAGS0, 8'h04);
    host.bad_op(r);
    check("bare op", 32'(r), 32'(B_NACK));
  endtask
  task automatic t_role;
    wr(A_SEC_NV, 8'h51, B_ACK);
    check("node", 32'(node), 32'h1);
    wr(A_SEC_NV, 8'h41, B_NACK);
    cleared = 1'b1;
    wr(A_SEC_NV, 8'h41, B_ACK);
    check("admin", 32'(node), 32'h0);
    cleared = 1'b0;
    wr(A_SEC_NV, 8'h51, B_ACK);
  endtask
  task automatic t_hold;
    own = 32'hA5A5_0001;
    push = 1'b1;
    for (int i = 0; i < ADMIN * TICK + 40 && n_keygen == 0; i++)
      step(1);
    step(2);
    check("hold pulses", 32'(n_keygen), 32'h1);
    check("hold role", 32'(node), 32'h0);
    check("hold last", last, own);
    measure(FAST_HALF_MS * TICK);
    push = 1'b0;
    step(20);
  endtask
  task automatic t_restore;
    repeat (4) begin
      push = 1'b1;
      step(8);
      push = 1'b0;
      step(8);
    end
    push = 1'b1;
    step(40);
    push = 1'b0;
    step(4);
    check("restore pulses", 32'(n_restore), 32'h1);
    rd(A_SEC_NV, OPT_DEFAULT);
    rd(A_SEC_VOL, OPT_DEFAULT);
  endtask
  task automatic t_led;
    search = 1'b1;
    measure(SLOW_HALF_MS * TICK);
    paired = 1'b1;
    measure(FAST_HALF_MS * TICK);
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    step(6);
    reset_i = 1'b0;
    step(1);
    t_reset;
    t_address;
    t_plain;
    t_lock;
    t_bus;
    t_role;
    t_hold;
    t_restore;
    t_led;
    end_sim;
  end
  initial begin
    #(40_000 * 100);
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
